// file: sram_port_pkg.sv
// Shared constants, state enumeration and lane helpers for the burst SRAM port.
// Assumes one 36-bit array location holds two 18-bit words of two 9-bit lanes each.
package sram_port_pkg;

  // Data organisation
  localparam int WORD_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES_PER_WORD = 2;
  localparam int WORDS_PER_LOC = 2;
  localparam int LOC_W = WORD_W * WORDS_PER_LOC;
  localparam int LOC_LANES = LANES_PER_WORD * WORDS_PER_LOC;
  localparam int ADDR_W_DEFAULT = 22;
  localparam int BURST_BIT = 0;

  // Active-low lane mask patterns
  localparam logic [LANES_PER_WORD-1:0] MASK_N_ALL = 2'h0;
  localparam logic [LANES_PER_WORD-1:0] MASK_N_NONE = 2'h3;

  // Pin synchroniser stages
  localparam int SYNC_W = 3;
  localparam int SYNC_MID = 1;
  localparam int SYNC_LAST = 2;

  // Drive impedance calibration
  localparam int CAL_PERIOD_CYCLES = 1024;
  localparam int CAL_CNT_W = $clog2(CAL_PERIOD_CYCLES);
  localparam logic [CAL_CNT_W-1:0] CAL_LAST = CAL_CNT_W'(CAL_PERIOD_CYCLES - 1);
  localparam logic [CAL_CNT_W-1:0] CAL_ZERO = '0;
  localparam logic [CAL_CNT_W-1:0] CAL_STEP = CAL_CNT_W'(1);
  localparam int DRIVE_W = 5;
  localparam logic [DRIVE_W-1:0] DRIVE_CODE_RESET = 5'h10;
  localparam logic [DRIVE_W-1:0] DRIVE_CODE_MAX = 5'h1F;
  localparam logic [DRIVE_W-1:0] DRIVE_CODE_MIN = 5'h00;
  localparam logic [DRIVE_W-1:0] DRIVE_STEP = 5'h01;

  // Strap observation window, longer than two output clock periods
  localparam int STRAP_WIN_CYCLES = 32;
  localparam int STRAP_CNT_W = $clog2(STRAP_WIN_CYCLES);
  localparam logic [STRAP_CNT_W-1:0] STRAP_LAST = STRAP_CNT_W'(STRAP_WIN_CYCLES - 1);
  localparam logic [STRAP_CNT_W-1:0] STRAP_STEP = STRAP_CNT_W'(1);

  typedef enum logic {STRAP_WAIT, STRAP_DONE} strap_state_t;

  // Overwrite the lanes of base whose enable is set
  function automatic logic [LOC_W-1:0] lane_merge(
    input logic [LOC_W-1:0] base,
    input logic [LOC_W-1:0] data,
    input logic [LOC_LANES-1:0] en
  );
    logic [LOC_W-1:0] res;
    res = base;
    for (int i = 0; i < LOC_LANES; i++)
    begin
      if (en[i])
      begin
        res[i*LANE_W +: LANE_W] = data[i*LANE_W +: LANE_W];
      end
    end
    return res;
  endfunction : lane_merge

  // Select one word of a location by burst index
  function automatic logic [WORD_W-1:0] word_pick(
    input logic [LOC_W-1:0] loc,
    input logic idx
  );
    return idx ? loc[LOC_W-1:WORD_W] : loc[WORD_W-1:0];
  endfunction : word_pick

endpackage : sram_port_pkg

// file: ddr_edge_reg.sv
// Enabled rising-edge register used for the half-cycle data paths of the port.
// Assumes its clock is one of the documented pin clocks and d_i is stable at its edge.
`timescale 1ns/1ps
module ddr_edge_reg #(
  parameter int W = 1
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] q;
  } edge_state_t;

  edge_state_t state_r;
  edge_state_t state_nxt;

  // Hold while disabled so a frozen port keeps its last word
  always_comb
  begin
    state_nxt = state_r;
    if (en_i)
    begin
      state_nxt.q = d_i;
    end
  end

  // Cleared at reset so the read path starts idle
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign q_o = state_r.q;

endmodule : ddr_edge_reg

// file: ddr_burst_sram_port.sv
// Device side of a two-word burst DDR SRAM: command capture, array with posted
// write and bypass, read launch on the output clocks, echo clocks, drive calibration.
// Assumes K/K# and C/C# arrive as clocks from the controller, clock_i runs free,
// and clock_en_i comes from logic on clock_i.
`timescale 1ns/1ps
module ddr_burst_sram_port #(
  parameter int ADDR_W = sram_port_pkg::ADDR_W_DEFAULT
)
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic clock_en_i,
  input wire logic k_clk_i,
  input wire logic k_n_clk_i,
  input wire logic c_clk_i,
  input wire logic c_n_clk_i,
  input wire logic transfer_start_n_i,
  input wire logic read_not_write_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [sram_port_pkg::WORD_W-1:0] dq_i,
  input wire logic [sram_port_pkg::LANES_PER_WORD-1:0] lane_write_mask_n_i,
  input wire logic impedance_ref_pin_i,
  output logic [sram_port_pkg::WORD_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic echo_strobe_pos_o,
  output logic echo_strobe_neg_o,
  output logic [sram_port_pkg::DRIVE_W-1:0] drive_code_o,
  output logic single_clock_mode_o
);
  import sram_port_pkg::*;

  localparam int LOC_AW = ADDR_W - 1;
  localparam int DEPTH = 2 ** LOC_AW;

  typedef struct packed {
    logic [SYNC_W-1:0] ref_s;
    logic ref_f;
    logic [SYNC_W-1:0] strap_s;
    strap_state_t strap_state;
    logic [STRAP_CNT_W-1:0] strap_cnt;
    logic single_mode;
    logic [CAL_CNT_W-1:0] cal_cnt;
    logic [DRIVE_W-1:0] drive_code;
    logic en_q;
  } sys_state_t;

  typedef struct packed {
    logic [SYNC_W-1:0] en_s;
    logic run;
    logic rd_pend;
    logic [ADDR_W-1:0] rd_addr;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic wr_stage;
    logic [ADDR_W-1:0] ws_addr;
    logic [WORD_W-1:0] w1;
    logic [LANES_PER_WORD-1:0] e1;
    logic pw_valid;
    logic [LOC_AW-1:0] pw_addr;
    logic [LOC_W-1:0] pw_data;
    logic [LOC_LANES-1:0] pw_en;
    logic rd_valid;
    logic [WORD_W-1:0] rd_w1;
    logic [WORD_W-1:0] rd_w2;
  } link_state_t;

  // Strap chain starts high: a cleared chain would read as a running C pair and
  // veto single-clock mode before the first real sample arrives
  localparam sys_state_t SYS_RESET = '{
    ref_s: '0, ref_f: 1'b0, strap_s: '1, strap_state: STRAP_WAIT, strap_cnt: '0,
    single_mode: 1'b0, cal_cnt: CAL_ZERO, drive_code: DRIVE_CODE_RESET, en_q: 1'b0};
  localparam link_state_t LINK_RESET = '0;

  sys_state_t sys_r;
  sys_state_t sys_nxt;
  link_state_t link_r;
  link_state_t link_nxt;

  logic [LOC_W-1:0] mem [0:DEPTH-1];

  logic out_p_clk;
  logic out_n_clk;
  logic rd_go;
  logic wr_go;
  logic commit_en;
  logic [LOC_AW-1:0] addr_loc;
  logic [LOC_AW-1:0] rd_loc;
  logic [LOC_AW-1:0] ws_loc;
  logic ws_a0;
  logic [LOC_W-1:0] ws_data;
  logic [LOC_LANES-1:0] ws_en;
  logic [LOC_W-1:0] rd_data;
  logic [WORD_W+LANES_PER_WORD-1:0] w2_q;
  logic [2*WORD_W:0] fall_q;
  logic [WORD_W:0] rise_q;

  // System domain: pin syncs, power-on strap, periodic drive calibration
  always_comb
  begin
    sys_nxt = sys_r;
    // Sync chains keep running while frozen so they never hold stale samples
    sys_nxt.ref_s = {sys_r.ref_s[SYNC_W-2:0], impedance_ref_pin_i};
    sys_nxt.strap_s = {sys_r.strap_s[SYNC_W-2:0], c_clk_i & c_n_clk_i};
    sys_nxt.en_q = clock_en_i;
    if (clock_en_i)
    begin
      if (sys_r.ref_s[SYNC_MID] == sys_r.ref_s[SYNC_LAST])
      begin
        sys_nxt.ref_f = sys_r.ref_s[SYNC_LAST];
      end
      // Strap must read high over a whole window; a running C pair reads low
      case (sys_r.strap_state)
        STRAP_WAIT:
        begin
          if (sys_r.strap_cnt == '0)
          begin
            sys_nxt.single_mode = 1'b1;
          end
          if (sys_r.strap_s[SYNC_MID] == sys_r.strap_s[SYNC_LAST] &&
              !sys_r.strap_s[SYNC_LAST])
          begin
            sys_nxt.single_mode = 1'b0;
          end
          sys_nxt.strap_cnt = sys_r.strap_cnt + STRAP_STEP;
          if (sys_r.strap_cnt == STRAP_LAST)
          begin
            sys_nxt.strap_state = STRAP_DONE;
          end
        end
        STRAP_DONE:
        begin
          sys_nxt.strap_state = STRAP_DONE;
        end
        default:
        begin
          sys_nxt.strap_state = STRAP_WAIT;
        end
      endcase
      // One step per period limits how fast the driver strength can move
      if (sys_r.cal_cnt == CAL_LAST)
      begin
        sys_nxt.cal_cnt = CAL_ZERO;
        if (sys_r.ref_f && sys_r.drive_code != DRIVE_CODE_MAX)
        begin
          sys_nxt.drive_code = sys_r.drive_code + DRIVE_STEP;
        end
        else if (!sys_r.ref_f && sys_r.drive_code != DRIVE_CODE_MIN)
        begin
          sys_nxt.drive_code = sys_r.drive_code - DRIVE_STEP;
        end
      end
      else
      begin
        sys_nxt.cal_cnt = sys_r.cal_cnt + CAL_STEP;
      end
    end
  end

  // System domain register
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sys_r <= SYS_RESET;
    end
    else
    begin
      sys_r <= sys_nxt;
    end
  end

  // Output timing clocks: the K pair replaces the C pair in single-clock mode
  assign out_p_clk = sys_r.single_mode ? k_clk_i : c_clk_i;
  assign out_n_clk = sys_r.single_mode ? k_n_clk_i : c_n_clk_i;

  // Commands are decoded from controls sampled at the positive K rise only
  assign rd_go = link_r.run && !transfer_start_n_i && read_not_write_i;
  assign wr_go = link_r.run && !transfer_start_n_i && !read_not_write_i;
  assign addr_loc = addr_i[ADDR_W-1:BURST_BIT+1];
  assign rd_loc = link_r.rd_addr[ADDR_W-1:BURST_BIT+1];
  assign ws_loc = link_r.ws_addr[ADDR_W-1:BURST_BIT+1];
  assign ws_a0 = link_r.ws_addr[BURST_BIT];
  assign commit_en = link_r.run && link_r.wr_stage && link_r.pw_valid;

  // Place the two write words by burst order; K# word comes from the half-cycle reg
  always_comb
  begin
    if (ws_a0)
    begin
      ws_data = {link_r.w1, w2_q[WORD_W-1:0]};
      ws_en = {link_r.e1, ~w2_q[WORD_W+LANES_PER_WORD-1:WORD_W]};
    end
    else
    begin
      ws_data = {w2_q[WORD_W-1:0], link_r.w1};
      ws_en = {~w2_q[WORD_W+LANES_PER_WORD-1:WORD_W], link_r.e1};
    end
  end

  // Read fetch: array, then posted write, then the write being posted this edge
  always_comb
  begin
    rd_data = mem[rd_loc];
    if (link_r.pw_valid && link_r.pw_addr == rd_loc)
    begin
      rd_data = lane_merge(rd_data, link_r.pw_data, link_r.pw_en);
    end
    if (link_r.wr_stage && ws_loc == rd_loc)
    begin
      rd_data = lane_merge(rd_data, ws_data, ws_en);
    end
  end

  // Link domain: three-stage command pipeline on the positive K rise
  always_comb
  begin
    link_nxt = link_r;
    link_nxt.en_s = {link_r.en_s[SYNC_W-2:0], sys_r.en_q};
    if (link_r.en_s[SYNC_MID] == link_r.en_s[SYNC_LAST])
    begin
      link_nxt.run = link_r.en_s[SYNC_LAST];
    end
    if (link_r.run)
    begin
      // Cycle t: a new command every rise; no command leaves pipeline idle
      link_nxt.rd_pend = rd_go;
      link_nxt.wr_pend = wr_go;
      if (rd_go)
      begin
        link_nxt.rd_addr = addr_i;
      end
      if (wr_go)
      begin
        link_nxt.wr_addr = addr_i;
      end
      // Cycle t+1: first write word and its masks, read location fetched
      link_nxt.wr_stage = link_r.wr_pend;
      if (link_r.wr_pend)
      begin
        link_nxt.w1 = dq_i;
        link_nxt.e1 = ~lane_write_mask_n_i;
        link_nxt.ws_addr = link_r.wr_addr;
      end
      link_nxt.rd_valid = link_r.rd_pend;
      if (link_r.rd_pend)
      begin
        link_nxt.rd_w1 = word_pick(rd_data, link_r.rd_addr[BURST_BIT]);
        link_nxt.rd_w2 = word_pick(rd_data, ~link_r.rd_addr[BURST_BIT]);
      end
      // Cycle t+2: completed write parks in the posted registers
      if (link_r.wr_stage)
      begin
        link_nxt.pw_valid = 1'b1;
        link_nxt.pw_addr = ws_loc;
        link_nxt.pw_data = ws_data;
        link_nxt.pw_en = ws_en;
      end
    end
  end

  // Link domain register
  always_ff @(posedge k_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      link_r <= LINK_RESET;
    end
    else
    begin
      link_r <= link_nxt;
    end
  end

  // Array write: the older posted write lands when the next write completes
  always_ff @(posedge k_clk_i)
  begin
    if (commit_en)
    begin
      mem[link_r.pw_addr] <= lane_merge(mem[link_r.pw_addr], link_r.pw_data, link_r.pw_en);
    end
  end

  // Second write word and masks on K# rise; read on the next K rise, half a cycle later
  ddr_edge_reg #(.W(WORD_W + LANES_PER_WORD)) u_wr_word2 (
    .clk_i(k_n_clk_i),
    .rst_n_i(rst_n_i),
    .en_i(link_r.run),
    .d_i({lane_write_mask_n_i, dq_i}),
    .q_o(w2_q)
  );

  // First word launched on the negative output clock; K words are stable here
  ddr_edge_reg #(.W(2 * WORD_W + 1)) u_rd_fall (
    .clk_i(out_n_clk),
    .rst_n_i(rst_n_i),
    .en_i(link_r.run),
    .d_i({link_r.rd_valid, link_r.rd_w1, link_r.rd_w2}),
    .q_o(fall_q)
  );

  // Second word taken from the fall register so it never samples a changing K word
  ddr_edge_reg #(.W(WORD_W + 1)) u_rd_rise (
    .clk_i(out_p_clk),
    .rst_n_i(rst_n_i),
    .en_i(link_r.run),
    .d_i({fall_q[2*WORD_W], fall_q[WORD_W-1:0]}),
    .q_o(rise_q)
  );

  // Phase select by output clock level gives one word per output edge
  assign dq_o = out_p_clk ? rise_q[WORD_W-1:0] : fall_q[2*WORD_W-1:WORD_W];
  assign dq_oe_o = out_p_clk ? rise_q[WORD_W] : fall_q[2*WORD_W];
  assign echo_strobe_pos_o = out_p_clk;
  assign echo_strobe_neg_o = out_n_clk;
  assign drive_code_o = sys_r.drive_code;
  assign single_clock_mode_o = sys_r.single_mode;

  // Link domain checks
  AST_RD_LATENCY: assert property (@(posedge k_clk_i) disable iff (!rst_n_i)
    rd_go ##1 link_r.run |=> link_r.rd_valid)
    else $error("read word not ready two K rises after command");

  AST_RD_B2B: assert property (@(posedge k_clk_i) disable iff (!rst_n_i)
    rd_go ##1 rd_go ##1 link_r.run |=> link_r.rd_valid && $past(link_r.rd_valid))
    else $error("back to back read dropped");

  AST_WR_POST: assert property (@(posedge k_clk_i) disable iff (!rst_n_i)
    wr_go ##1 link_r.run ##1 link_r.run |=> link_r.pw_valid &&
    link_r.pw_addr == $past(addr_loc, 3))
    else $error("write not posted at its location");

  AST_POST_HOLD: assert property (@(posedge k_clk_i) disable iff (!rst_n_i)
    !link_r.wr_stage |=> $stable(link_r.pw_data) && $stable(link_r.pw_addr))
    else $error("posted write changed without a new write");

  AST_BYPASS: assert property (@(posedge k_clk_i) disable iff (!rst_n_i)
    wr_go ##1 (rd_go && addr_i == $past(addr_i) && lane_write_mask_n_i == MASK_N_ALL)
    ##1 link_r.run |=> link_r.rd_w1 == $past(dq_i, 2))
    else $error("read after write missed newest data");

  AST_IDLE: assert property (@(posedge k_clk_i) disable iff (!rst_n_i)
    link_r.run && transfer_start_n_i |=> !link_r.rd_pend && !link_r.wr_pend)
    else $error("command started without transfer strobe");

  AST_MASK: assert property (@(posedge k_clk_i) disable iff (!rst_n_i)
    wr_go && !addr_i[BURST_BIT] ##1 (link_r.run && lane_write_mask_n_i == MASK_N_NONE)
    ##1 link_r.run |=> link_r.pw_en[LANES_PER_WORD-1:0] == '0)
    else $error("masked lane enabled for write");

  // Output clock check
  AST_FLOAT: assert property (@(posedge out_p_clk) disable iff (!rst_n_i)
    link_r.run && !fall_q[2*WORD_W] |=> !rise_q[WORD_W])
    else $error("output still driven after read ended");

  // System domain checks
  AST_CAL_WRAP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    sys_r.cal_cnt == CAL_LAST && clock_en_i |=> sys_r.cal_cnt == CAL_ZERO)
    else $error("calibration period wrong");

  AST_CAL_QUIET: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !(sys_r.cal_cnt == CAL_LAST && clock_en_i) |=> $stable(sys_r.drive_code))
    else $error("drive code moved between calibration ticks");

  AST_STRAP_FIXED: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    sys_r.strap_state == STRAP_DONE |=> $stable(sys_r.single_mode))
    else $error("clock mode changed after strap");

  COV_READ: cover property (@(posedge k_clk_i) disable iff (!rst_n_i)
    rd_go ##2 link_r.rd_valid);
  COV_WR_B2B: cover property (@(posedge k_clk_i) disable iff (!rst_n_i)
    wr_go ##1 wr_go ##2 commit_en);
  COV_BYPASS: cover property (@(posedge k_clk_i) disable iff (!rst_n_i)
    wr_go ##1 (rd_go && addr_i == $past(addr_i)) ##2 link_r.rd_valid);
  COV_CAL: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    sys_r.cal_cnt == CAL_LAST && clock_en_i);

endmodule : ddr_burst_sram_port

// file: sram_ctrl_model.sv
// Controller model facing the burst SRAM port: free K pair, output clocks, commands, write data.
// Assumes the bench issues commands from one process and collects read words from rd_q.
`timescale 1ns/1ps
module sram_ctrl_model #(
  parameter int ADDR_W = 6
)
(
  input wire logic c_tied_i,
  input wire logic [17:0] dq_i,
  input wire logic dq_oe_i,
  output logic k_clk_o,
  output logic k_n_clk_o,
  output logic c_clk_o,
  output logic c_n_clk_o,
  output logic transfer_start_n_o,
  output logic read_not_write_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [17:0] dq_o,
  output logic [1:0] lane_write_mask_n_o
);
  logic [17:0] rd_q[$];
  int rd_t_q[$];
  int kcnt = 0;

  // Odd start offset keeps K unrelated in phase to the system clock
  initial
  begin
    k_clk_o = 1'b0;
    transfer_start_n_o = 1'b1;
    read_not_write_o = 1'b0;
    addr_o = '0;
    dq_o = '0;
    lane_write_mask_n_o = 2'h3;
    #3.7;
    forever #62.5 k_clk_o = ~k_clk_o;
  end
  assign k_n_clk_o = ~k_clk_o;
  // Strapped high selects single-clock mode, else the output pair follows K
  assign c_clk_o = c_tied_i | k_clk_o;
  assign c_n_clk_o = c_tied_i | k_n_clk_o;

  always @(posedge k_clk_o) kcnt <= kcnt + 1;

  // Read words are taken a quarter period after each launching edge, once settled
  always @(posedge k_clk_o or posedge k_n_clk_o)
  begin
    #31;
    if (dq_oe_i === 1'b1)
    begin
      rd_q.push_back(dq_i);
      rd_t_q.push_back(kcnt);
    end
  end

  // Word1 before K rise t+1, word2 before K# rise t+1; released lines show the inverse
  task automatic wr_data(input logic [17:0] w1, input logic [17:0] w2, input logic [1:0] m1,
    input logic [1:0] m2);
    @(negedge k_clk_o);
    #31;
    dq_o = w1;
    lane_write_mask_n_o = m1;
    @(posedge k_clk_o);
    #31;
    dq_o = w2;
    lane_write_mask_n_o = m2;
    @(negedge k_clk_o);
    #20;
    dq_o = ~w2;
    lane_write_mask_n_o = ~m2;
  endtask : wr_data

  // One command per K rise; this bank owns its own start strobe
  task automatic issue(input logic rw, input logic [ADDR_W-1:0] a, input logic [17:0] w1,
    input logic [17:0] w2, input logic [1:0] m1, input logic [1:0] m2, output int t);
    @(negedge k_clk_o);
    #31;
    transfer_start_n_o = 1'b0;
    read_not_write_o = rw;
    addr_o = a;
    @(posedge k_clk_o);
    #20;
    t = kcnt;
    transfer_start_n_o = 1'b1;
    read_not_write_o = ~rw;
    addr_o = ~a;
    if (!rw)
      fork
        wr_data(w1, w2, m1, m2);
      join_none
  endtask : issue
endmodule : sram_ctrl_model

// file: ddr_two_word_burst_sram_port_tb_top.sv
// Self-checking bench for the burst SRAM port, driven through the controller model.
// Assumes the port's array keeps its contents across a reset.
`timescale 1ns/1ps
module ddr_two_word_burst_sram_port_tb_top;
  import sram_port_pkg::*;
  localparam int AW = 6;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic clock_en_i = 1'b1;
  logic imp_ref = 1'b1;
  logic c_tied = 1'b0;
  logic k_clk, k_n_clk, c_clk, c_n_clk, start_n, rnw, dq_oe, echo_p, echo_n, single_mode;
  logic [AW-1:0] addr;
  logic [WORD_W-1:0] dq_w, dq_r;
  logic [LANES_PER_WORD-1:0] mask_n;
  logic [DRIVE_W-1:0] drive_code;
  logic [LOC_W-1:0] mem [0:31];
  logic [WORD_W-1:0] exp_w[$];
  int exp_t[$];
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  int rel = 0;

  sram_ctrl_model #(.ADDR_W(AW)) ctrl (.c_tied_i(c_tied), .dq_i(dq_r), .dq_oe_i(dq_oe),
    .k_clk_o(k_clk), .k_n_clk_o(k_n_clk), .c_clk_o(c_clk), .c_n_clk_o(c_n_clk),
    .transfer_start_n_o(start_n), .read_not_write_o(rnw), .addr_o(addr), .dq_o(dq_w),
    .lane_write_mask_n_o(mask_n));
  ddr_burst_sram_port #(.ADDR_W(AW)) uut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .clock_en_i(clock_en_i), .k_clk_i(k_clk), .k_n_clk_i(k_n_clk), .c_clk_i(c_clk),
    .c_n_clk_i(c_n_clk), .transfer_start_n_i(start_n), .read_not_write_i(rnw),
    .addr_i(addr), .dq_i(dq_w), .lane_write_mask_n_i(mask_n), .impedance_ref_pin_i(imp_ref),
    .dq_o(dq_r), .dq_oe_o(dq_oe), .echo_strobe_pos_o(echo_p), .echo_strobe_neg_o(echo_n),
    .drive_code_o(drive_code), .single_clock_mode_o(single_mode));

  always #5 clock_i = ~clock_i;

  // Cycle count with a ceiling well above the expected run of about 3100 cycles
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc > 12000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : check

  task automatic wait_cyc(input int n);
    while (cyc - rel < n)
      @(negedge clock_i);
  endtask : wait_cyc

  // Reference array updated at issue time, so reads always expect the newest data
  task automatic mwrite(input logic [AW-1:0] a, input logic [17:0] w1, input logic [17:0] w2,
    input logic [1:0] m1, input logic [1:0] m2);
    int t;
    logic [35:0] d;
    logic [3:0] en;
    d = a[0] ? {w1, w2} : {w2, w1};
    en = a[0] ? {~m1, ~m2} : {~m2, ~m1};
    for (int i = 0; i < 4; i++)
      if (en[i])
        mem[a[AW-1:1]][i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
    ctrl.issue(1'b0, a, w1, w2, m1, m2, t);
  endtask : mwrite

  task automatic mread(input logic [AW-1:0] a);
    int t;
    logic [35:0] loc;
    loc = mem[a[AW-1:1]];
    ctrl.issue(1'b1, a, 18'h0, 18'h0, 2'h3, 2'h3, t);
    exp_w.push_back(a[0] ? loc[35:18] : loc[17:0]);
    exp_w.push_back(a[0] ? loc[17:0] : loc[35:18]);
    exp_t.push_back(t + 1);
    exp_t.push_back(t + 2);
  endtask : mread

  // Every driven half cycle must be an expected word at its expected K cycle
  task automatic drain(input string what);
    repeat (4) @(posedge k_clk);
    check({what, " words"}, 36'(exp_w.size()), 36'(ctrl.rd_q.size()));
    while (exp_w.size() > 0 && ctrl.rd_q.size() > 0)
    begin
      check(what, exp_w.pop_front(), ctrl.rd_q.pop_front());
      check({what, " cycle"}, 36'(exp_t.pop_front()),
        36'(ctrl.rd_t_q.pop_front()));
    end
    exp_w.delete();
    exp_t.delete();
    ctrl.rd_q.delete();
    ctrl.rd_t_q.delete();
  endtask : drain

  task automatic t_reset();
    wait_cyc(40);
    check("oe at reset", 36'h0, 36'(dq_oe));
    check("mode", 36'h0, 36'(single_mode));
    check("drive", 36'h10, 36'(drive_code));
    repeat (20)
    begin
      @(negedge clock_i);
      check("echo pos", 36'(c_clk), 36'(echo_p));
      check("echo neg", 36'(c_n_clk), 36'(echo_n));
    end
    $display("test reset done");
  endtask : t_reset

  task automatic t_calib();
    wait_cyc(1000);
    check("drive early", 36'h10, 36'(drive_code));
    wait_cyc(1100);
    check("drive up", 36'h11, 36'(drive_code));
    // A frozen enable must stretch the period by exactly the frozen cycles
    imp_ref = 1'b0;
    clock_en_i = 1'b0;
    wait_cyc(1200);
    clock_en_i = 1'b1;
    wait_cyc(2100);
    check("drive frozen", 36'h11, 36'(drive_code));
    wait_cyc(2200);
    check("drive down", 36'h10, 36'(drive_code));
    $display("test calib done");
  endtask : t_calib

  // Reads straight after write hit the write being posted, then the posted data; a later write commits it
  task automatic t_basic();
    mwrite(6'h06, 18'h12345, 18'h2ABCD, 2'h0, 2'h0);
    mread(6'h06);
    mread(6'h07);
    drain("bypass");
    mwrite(6'h08, 18'h3C3C3, 18'h05A5A, 2'h0, 2'h0);
    @(posedge k_clk);
    mread(6'h06);
    mread(6'h09);
    drain("array");
    $display("test basic done");
  endtask : t_basic

  task automatic t_masks();
    mwrite(6'h10, 18'h11111, 18'h22222, 2'h0, 2'h0);
    for (int m = 0; m < 4; m++)
      mwrite(AW'(17 - m % 2), 18'h3FFFF - 18'(m), 18'h15555 + 18'(m), 2'(m), ~2'(m));
    mread(6'h10);
    mread(6'h11);
    drain("mask bypass");
    mwrite(6'h3E, 18'h0F0F0, 18'h30303, 2'h0, 2'h0);
    @(posedge k_clk);
    mread(6'h10);
    drain("mask array");
    $display("test masks done");
  endtask : t_masks

  task automatic t_b2b();
    for (int i = 0; i < 8; i++)
      mwrite(AW'(32 + i), 18'h01111 * 18'(i), 18'h2AAAA ^ 18'(i), 2'h0, 2'h0);
    for (int i = 0; i < 8; i++)
      mread(AW'(39 - i));
    mread(6'h21);
    @(posedge k_clk);
    mwrite(6'h21, 18'h1E1E1, 18'h0D0D0, 2'h1, 2'h2);
    mread(6'h21);
    drain("back to back");
    $display("test b2b done");
  endtask : t_b2b

  task automatic t_single();
    @(negedge clock_i);
    c_tied = 1'b1;
    rst_n_i = 1'b0;
    repeat (30) @(negedge clock_i);
    rst_n_i = 1'b1;
    rel = cyc;
    wait_cyc(40);
    repeat (6) @(posedge k_clk);
    // Look away from the K edge so the echo mux has settled
    @(negedge clock_i);
    check("single mode", 36'h1, 36'(single_mode));
    check("oe idle", 36'h0, 36'(dq_oe));
    check("echo k", 36'(k_clk), 36'(echo_p));
    check("echo k neg", 36'(k_n_clk), 36'(echo_n));
    mwrite(6'h2C, 18'h2468A, 18'h13579, 2'h0, 2'h0);
    mread(6'h2D);
    drain("single");
    $display("test single done");
  endtask : t_single

  initial
  begin
    repeat (6) @(negedge clock_i);
    rst_n_i = 1'b1;
    rel = cyc;
    t_reset();
    t_calib();
    t_basic();
    t_masks();
    t_b2b();
    t_single();
    print_verdict();
  end
endmodule : ddr_two_word_burst_sram_port_tb_top
